// file: rtl/slp_defs.svh
`ifndef SLP_DEFS_SVH
`define SLP_DEFS_SVH

// management register addresses
`define SLP_ADDR_CTRL 5'h10
`define SLP_ADDR_SHADOW 5'h1c

// shadow field of register 1ch and its write-enable bit
`define SLP_SHD_WE_BIT 15
`define SLP_SHD_MSB 14
`define SLP_SHD_LSB 10
`define SLP_SHD_SEL_LOW 5'h0d
`define SLP_SHD_SEL_HIGH 5'h0e
`define SLP_SHD_STRAP 5'h1e

// reset values of the selector pairs and of register 10h
`define SLP_SEL_LOW_RESET 8'h10
`define SLP_SEL_HIGH_RESET 8'h63
`define SLP_CTRL_RESET 16'h0000

// register 10h bit positions
`define SLP_CTRL_IRQ_DIS 12
`define SLP_CTRL_FORCE_ON 4
`define SLP_CTRL_FORCE_OFF 3

// indicator function codes
`define SLP_FN_RATE_LOW 4'h0
`define SLP_FN_RATE_HIGH 4'h1
`define SLP_FN_ACTIVITY 4'h3
`define SLP_FN_IRQ 4'h6
`define SLP_FN_OFF 4'he
`define SLP_FN_ON 4'hf

// test strap codes and address bases
`define SLP_TEST_NORMAL 2'b00
`define SLP_TEST_JTAG 2'b01
`define SLP_TEST_ADDR_HIGH 2'b11
`define SLP_ADDR_BASE_LOW 5'h00
`define SLP_ADDR_BASE_HIGH 5'h18

// settle count after reset release; straps are captured on the next cycle, four in all, synchroniser depth included
`define SLP_STRAP_SETTLE 2'd3

`endif

// file: rtl/slp_pkg.sv
`default_nettype none
package slp_pkg;

  typedef enum logic [1:0] {
    SLP_SPEED_10,
    SLP_SPEED_100,
    SLP_SPEED_1000
  } slp_speed_type;

  typedef enum logic [1:0] {
    SLP_MAC_3V3,
    SLP_MAC_2V5,
    SLP_MAC_LOW_SWING,
    SLP_MAC_RESERVED
  } slp_mac_mode_type;

  typedef enum logic {
    SLP_STRAP_WAIT,
    SLP_STRAP_RUN
  } slp_strap_state_type;

endpackage

`default_nettype wire

// file: rtl/slp_indicator_drive.sv
`timescale 1ns/1ps
`default_nettype none
`include "slp_defs.svh"

module slp_indicator_drive (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // selection
  input wire logic enable_i,
  input wire logic [3:0] select_i,
  input wire logic [15:0] func_i,
  input wire logic active_low_i,
  input wire logic force_on_i,
  input wire logic force_off_i,
  // fixed-meaning overrides
  input wire logic override_en_i,
  input wire logic override_on_i,
  input wire logic jtag_en_i,
  input wire logic jtag_out_i,
  input wire logic jtag_oe_i,
  // pin drive
  output logic pin_out_o,
  output logic pin_oe_o
);

  logic next_out;
  logic next_oe;
  logic on;
  logic is_irq;

  // pick the function, apply force and polarity, then the pin driver style
  always_comb begin
    on = 1'b0;
    is_irq = 1'b0;
    next_out = 1'b0;
    next_oe = 1'b0;
    if (!enable_i) begin
      next_oe = 1'b0; // still sampling straps: pin is an input
    end else if (jtag_en_i) begin
      next_out = jtag_out_i;
      next_oe = jtag_oe_i;
    end else begin
      if (override_en_i) begin
        on = override_on_i;
      end else begin
        on = func_i[select_i];
        is_irq = (select_i == `SLP_FN_IRQ);
      end
      if (is_irq) begin
        next_out = 1'b0;
        next_oe = on; // open drain: pull low only while active
      end else begin
        if (force_on_i) begin
          on = 1'b1;
        end else if (force_off_i) begin
          on = 1'b0;
        end
        next_out = on ^ active_low_i;
        next_oe = 1'b1;
      end
    end
  end

  // pin driver flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_out_o <= next_out;
      pin_oe_o <= next_oe;
    end
  end

endmodule

`default_nettype wire

// file: rtl/slp_pin_config.sv
// Function
// - four indicator pins are strap inputs during reset, indicator outputs afterwards
// - strap high gives active-low output, strap low gives active-high output
// - four 4-bit selectors live in register 1ch shadows 01101 and 01110
// - pin one selector bits 3:0 reset 0000; pin two selector resets 0001
// - pin three bits 3:0 reset 0011; pin four bits 7:4 reset 0110
// - each function is an internal signal muxed to the pin by its selector
// - rate code pair: 00 gigabit, 01 hundred, 10 ten, 11 no link
// - test strap 01 hands pins three, two, one and address strap to jtag
// - test strap 00 or 11 means normal operation from strap pins
// - address is 0x0/0x1 with test strap 00, 0x18/0x19 with 11
// - pin four low: mac mode from pins three and two at reset
// - pin four high at reset enables compact rate indicator mode, except with test strap 01
// - compact mode pins two and one show 10 gigabit, 01 hundred, 11 otherwise
// - compact mode mac mode from pin three alone, low means 3.3 volt
// - pin four low: pin two is the low mac mode bit, active high
// - interrupt function pins are open drain unless overridden; others driven, except jtag pins one to three in test mode
// - register 10h bit 4 forces non-interrupt indicators on, bit 3 forces them off
`timescale 1ns/1ps
`default_nettype none
`include "slp_defs.svh"

module slp_pin_config (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // indicator pins, two-way
  input wire logic [3:0] indicator_pin_in_i,
  output logic [3:0] indicator_pin_out_o,
  output logic [3:0] indicator_pin_oe_o,
  // strap pins
  input wire logic [1:0] test_strap_i,
  input wire logic address_strap_bit_i,
  // core status feeding the indicator functions
  input wire logic link_up_i,
  input wire slp_pkg::slp_speed_type link_speed_i,
  input wire logic activity_i,
  input wire logic interrupt_i,
  // test access port
  input wire logic jtag_tdo_i,
  input wire logic jtag_tdo_en_i,
  output logic jtag_tdi_o,
  output logic jtag_tms_o,
  output logic jtag_tck_o,
  // derived configuration
  output logic strap_done_o,
  output logic test_mode_o,
  output logic [4:0] phy_addr_o,
  output slp_pkg::slp_mac_mode_type mac_mode_o,
  output logic compact_rate_led_o,
  // management register port
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o
);

  import slp_pkg::*;

  // pin synchronisers
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic [3:0] ind_sync;
  logic [1:0] test_sync;
  logic addr_sync;

  // strap capture and configuration state
  slp_strap_state_type state, next_state;
  logic [1:0] settle, next_settle;
  logic [3:0] strap_pins, next_strap_pins;
  logic [1:0] strap_test, next_strap_test;
  logic strap_addr, next_strap_addr;
  logic next_test_mode;
  logic [4:0] next_phy_addr;
  slp_mac_mode_type next_mac_mode;
  logic next_compact;

  // registers
  logic [7:0] indicator_select_low_pair, next_sel_low;
  logic [7:0] indicator_select_high_pair, next_sel_high;
  logic [15:0] ctrl, next_ctrl;
  logic [4:0] shadow_ptr, next_shadow_ptr;
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic [4:0] wr_shadow;

  // jtag pin samples
  logic next_tdi;
  logic next_tms;
  logic next_tck;

  // indicator functions and per-pin drive controls
  logic link_rate_code_low;
  logic link_rate_code_high;
  logic interrupt_indicator;
  logic [15:0] func_vec;
  logic [3:0] ovr_en;
  logic [3:0] ovr_on;
  logic [3:0] jtag_en;
  logic [3:0] jtag_out;
  logic [3:0] jtag_oe;
  logic [15:0] sel_all;

  // two flops on every pin before any logic reads it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= {address_strap_bit_i, test_strap_i, indicator_pin_in_i};
      pin_sync <= pin_meta;
    end
  end

  assign ind_sync = pin_sync[3:0];
  assign test_sync = pin_sync[5:4];
  assign addr_sync = pin_sync[6];

  // strap capture after reset release, then configuration derived once
  always_comb begin
    next_state = state;
    next_settle = settle;
    next_strap_pins = strap_pins;
    next_strap_test = strap_test;
    next_strap_addr = strap_addr;
    next_test_mode = test_mode_o;
    next_phy_addr = phy_addr_o;
    next_mac_mode = mac_mode_o;
    next_compact = compact_rate_led_o;
    case (state)
      SLP_STRAP_WAIT: begin
        if (settle == `SLP_STRAP_SETTLE) begin
          next_state = SLP_STRAP_RUN;
          next_strap_pins = ind_sync;
          next_strap_test = test_sync;
          next_strap_addr = addr_sync;
          next_test_mode = (test_sync == `SLP_TEST_JTAG);
          if (test_sync == `SLP_TEST_ADDR_HIGH) begin
            next_phy_addr = `SLP_ADDR_BASE_HIGH | {4'h0, addr_sync};
          end else if (test_sync == `SLP_TEST_NORMAL) begin
            next_phy_addr = `SLP_ADDR_BASE_LOW | {4'h0, addr_sync};
          end else begin
            next_phy_addr = `SLP_ADDR_BASE_LOW;
          end
          next_compact = ind_sync[3] && (test_sync != `SLP_TEST_JTAG);
          if (ind_sync[3]) begin
            next_mac_mode = slp_mac_mode_type'({ind_sync[2], 1'b0});
          end else begin
            next_mac_mode = slp_mac_mode_type'({ind_sync[2], ind_sync[1]});
          end
        end else begin
          next_settle = settle + 2'd1;
        end
      end
      SLP_STRAP_RUN: begin
        next_state = SLP_STRAP_RUN;
      end
      default: begin
        next_state = SLP_STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= SLP_STRAP_WAIT;
      settle <= 2'd0;
      strap_pins <= 4'h0;
      strap_test <= 2'b00;
      strap_addr <= 1'b0;
      test_mode_o <= 1'b0;
      phy_addr_o <= 5'h00;
      mac_mode_o <= SLP_MAC_3V3;
      compact_rate_led_o <= 1'b0;
      strap_done_o <= 1'b0;
    end else begin
      state <= next_state;
      settle <= next_settle;
      strap_pins <= next_strap_pins;
      strap_test <= next_strap_test;
      strap_addr <= next_strap_addr;
      test_mode_o <= next_test_mode;
      phy_addr_o <= next_phy_addr;
      mac_mode_o <= next_mac_mode;
      compact_rate_led_o <= next_compact;
      strap_done_o <= (next_state == SLP_STRAP_RUN);
    end
  end

  // management register access: 10h control, 1ch shadow-indexed
  assign wr_shadow = mgmt_wdata_i[`SLP_SHD_MSB:`SLP_SHD_LSB];

  always_comb begin
    next_sel_low = indicator_select_low_pair;
    next_sel_high = indicator_select_high_pair;
    next_ctrl = ctrl;
    next_shadow_ptr = shadow_ptr;
    next_rdata = mgmt_rdata_o;
    next_rvalid = 1'b0;
    if (mgmt_wr_i) begin
      if (mgmt_addr_i == `SLP_ADDR_CTRL) begin
        next_ctrl = mgmt_wdata_i;
      end else if (mgmt_addr_i == `SLP_ADDR_SHADOW) begin
        next_shadow_ptr = wr_shadow;
        if (mgmt_wdata_i[`SLP_SHD_WE_BIT] && wr_shadow == `SLP_SHD_SEL_LOW) begin
          next_sel_low = mgmt_wdata_i[7:0];
        end else if (mgmt_wdata_i[`SLP_SHD_WE_BIT] && wr_shadow == `SLP_SHD_SEL_HIGH) begin
          next_sel_high = mgmt_wdata_i[7:0];
        end
      end
    end
    if (mgmt_rd_i) begin
      next_rvalid = 1'b1;
      if (mgmt_addr_i == `SLP_ADDR_CTRL) begin
        next_rdata = ctrl;
      end else if (mgmt_addr_i == `SLP_ADDR_SHADOW && shadow_ptr == `SLP_SHD_SEL_LOW) begin
        next_rdata = {1'b0, shadow_ptr, 2'b00, indicator_select_low_pair};
      end else if (mgmt_addr_i == `SLP_ADDR_SHADOW && shadow_ptr == `SLP_SHD_SEL_HIGH) begin
        next_rdata = {1'b0, shadow_ptr, 2'b00, indicator_select_high_pair};
      end else if (mgmt_addr_i == `SLP_ADDR_SHADOW && shadow_ptr == `SLP_SHD_STRAP) begin
        next_rdata = {1'b0, shadow_ptr, strap_pins, strap_addr, strap_test, compact_rate_led_o, mac_mode_o};
      end else if (mgmt_addr_i == `SLP_ADDR_SHADOW) begin
        next_rdata = {1'b0, shadow_ptr, 10'h000};
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      indicator_select_low_pair <= `SLP_SEL_LOW_RESET;
      indicator_select_high_pair <= `SLP_SEL_HIGH_RESET;
      ctrl <= `SLP_CTRL_RESET;
      shadow_ptr <= 5'h00;
      mgmt_rdata_o <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      indicator_select_low_pair <= next_sel_low;
      indicator_select_high_pair <= next_sel_high;
      ctrl <= next_ctrl;
      shadow_ptr <= next_shadow_ptr;
      mgmt_rdata_o <= next_rdata;
      mgmt_rvalid_o <= next_rvalid;
    end
  end

  // jtag input samples, only meaningful in test mode
  always_comb begin
    next_tdi = 1'b0;
    next_tms = 1'b0;
    next_tck = 1'b0;
    if (test_mode_o) begin
      next_tdi = ind_sync[1];
      next_tms = ind_sync[0];
      next_tck = addr_sync;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      jtag_tdi_o <= 1'b0;
      jtag_tms_o <= 1'b0;
      jtag_tck_o <= 1'b0;
    end else begin
      jtag_tdi_o <= next_tdi;
      jtag_tms_o <= next_tms;
      jtag_tck_o <= next_tck;
    end
  end

  // internal indicator functions
  assign link_rate_code_high = !link_up_i || (link_speed_i == SLP_SPEED_10);
  assign link_rate_code_low = !link_up_i || (link_speed_i == SLP_SPEED_100);
  assign interrupt_indicator = interrupt_i && !ctrl[`SLP_CTRL_IRQ_DIS];

  always_comb begin
    func_vec = 16'h0000;
    func_vec[`SLP_FN_RATE_LOW] = link_rate_code_low;
    func_vec[`SLP_FN_RATE_HIGH] = link_rate_code_high;
    func_vec[`SLP_FN_ACTIVITY] = activity_i;
    func_vec[`SLP_FN_IRQ] = interrupt_indicator;
    func_vec[`SLP_FN_OFF] = 1'b0;
    func_vec[`SLP_FN_ON] = 1'b1;
  end

  // per-pin overrides: compact rate mode on pins one and two, jtag on one to three
  always_comb begin
    ovr_en = {2'b00, compact_rate_led_o, compact_rate_led_o};
    ovr_on = 4'h0;
    ovr_on[1] = !(link_up_i && link_speed_i == SLP_SPEED_100);
    ovr_on[0] = !(link_up_i && link_speed_i == SLP_SPEED_1000);
    jtag_en = {1'b0, {3{test_mode_o}}};
    jtag_out = {1'b0, jtag_tdo_i, 2'b00};
    jtag_oe = {1'b0, jtag_tdo_en_i, 2'b00};
  end

  assign sel_all = {indicator_select_high_pair, indicator_select_low_pair};

  // one driver per indicator pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      slp_indicator_drive u_drive (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(state == SLP_STRAP_RUN),
        .select_i(sel_all[4*gi+3:4*gi]),
        .func_i(func_vec),
        .active_low_i(strap_pins[gi]),
        .force_on_i(ctrl[`SLP_CTRL_FORCE_ON]),
        .force_off_i(ctrl[`SLP_CTRL_FORCE_OFF]),
        .override_en_i(ovr_en[gi]),
        .override_on_i(ovr_on[gi]),
        .jtag_en_i(jtag_en[gi]),
        .jtag_out_i(jtag_out[gi]),
        .jtag_oe_i(jtag_oe[gi]),
        .pin_out_o(indicator_pin_out_o[gi]),
        .pin_oe_o(indicator_pin_oe_o[gi])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// file: tb/slp_pin_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module slp_pin_monitor
  import slp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pins and test port
  input wire logic [3:0] indicator_pin_out_o,
  input wire logic [3:0] indicator_pin_oe_o,
  input wire logic jtag_tdo_i,
  input wire logic jtag_tdo_en_i,
  input wire logic jtag_tdi_o,
  input wire logic jtag_tms_o,
  input wire logic jtag_tck_o,
  // derived configuration
  input wire logic strap_done_o,
  input wire logic test_mode_o,
  input wire logic [4:0] phy_addr_o,
  input wire slp_pkg::slp_mac_mode_type mac_mode_o,
  input wire logic compact_rate_led_o,
  // register read side
  input wire logic mgmt_rd_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic mgmt_rvalid_o
);
  import slp_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // read request and its answer
  sequence rd_req; mgmt_rd_i; endsequence
  sequence rd_ans; mgmt_rvalid_o; endsequence
  pins_input_a: assert property (!strap_done_o |-> indicator_pin_oe_o == 4'h0)
    else $error("pins driven before straps latched");
  rd_answer_a: assert property (rd_req |=> rd_ans) else $error("read not answered");
  rd_only_a: assert property (rd_ans |-> $past(mgmt_rd_i)) else $error("answer without read");
  rdata_hold_a: assert property (!mgmt_rvalid_o |-> $stable(mgmt_rdata_o)) else $error("read data moved");
  strap_hold_a: assert property (strap_done_o ##1 strap_done_o |->
    $stable({phy_addr_o, mac_mode_o, compact_rate_led_o, test_mode_o})) else $error("strap value moved");
  addr_form_a: assert property (strap_done_o && !test_mode_o |->
    phy_addr_o[2:1] == 2'h0 && phy_addr_o[4] == phy_addr_o[3]) else $error("bad address");
  test_pins_a: assert property (test_mode_o |-> indicator_pin_oe_o[1:0] == 2'h0 &&
    phy_addr_o == 5'h00 && !compact_rate_led_o) else $error("test mode pins wrong");
  tdo_pass_a: assert property (test_mode_o && $past(test_mode_o) |->
    indicator_pin_oe_o[2] == $past(jtag_tdo_en_i) && indicator_pin_out_o[2] == $past(jtag_tdo_i))
    else $error("tdo not passed");
  jtag_idle_a: assert property (!test_mode_o |-> !jtag_tdi_o && !jtag_tms_o && !jtag_tck_o)
    else $error("jtag active outside test mode");
  compact_mac_a: assert property (compact_rate_led_o |-> !mac_mode_o[0])
    else $error("compact mac mode wrong");
endmodule
bind slp_pin_config slp_pin_monitor i_slp_pin_monitor (.clk_i, .reset_i, .indicator_pin_out_o,
  .indicator_pin_oe_o, .jtag_tdo_i, .jtag_tdo_en_i, .jtag_tdi_o, .jtag_tms_o, .jtag_tck_o,
  .strap_done_o, .test_mode_o, .phy_addr_o, .mac_mode_o, .compact_rate_led_o, .mgmt_rd_i,
  .mgmt_rdata_o, .mgmt_rvalid_o);
`default_nettype wire

// file: tb/slp_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module slp_board_model (
  // strap resistor levels
  input wire logic [3:0] strap_i,
  // device pin drive
  input wire logic [3:0] pin_out_i,
  input wire logic [3:0] pin_oe_i,
  // resolved pin level
  output logic [3:0] pin_level_o
);
  // a released pin rests at its strap resistor level, held steady by the board
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level_o[i] = pin_oe_i[i] ? pin_out_i[i] : strap_i[i];
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import slp_pkg::*;
  // design side signals
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] board_strap = 4'h0;
  logic [3:0] pin_level;
  logic [3:0] indicator_pin_out_o;
  logic [3:0] indicator_pin_oe_o;
  logic [1:0] test_strap_i = 2'h0;
  logic address_strap_bit_i = 1'b0;
  logic link_up_i = 1'b0;
  slp_speed_type link_speed_i = SLP_SPEED_10;
  logic activity_i = 1'b0;
  logic interrupt_i = 1'b0;
  logic jtag_tdo_i = 1'b0;
  logic jtag_tdo_en_i = 1'b0;
  logic jtag_tdi_o, jtag_tms_o, jtag_tck_o, strap_done_o, test_mode_o, compact_rate_led_o;
  logic [4:0] phy_addr_o;
  slp_mac_mode_type mac_mode_o;
  logic mgmt_wr_i = 1'b0;
  logic mgmt_rd_i = 1'b0;
  logic [4:0] mgmt_addr_i = 5'h00;
  logic [15:0] mgmt_wdata_i = 16'h0000;
  logic [15:0] mgmt_rdata_o;
  logic mgmt_rvalid_o;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  slp_speed_type spd [4] = '{SLP_SPEED_1000, SLP_SPEED_100, SLP_SPEED_10, SLP_SPEED_10};
  logic [1:0] compact_exp [4] = '{2'h3, 2'h0, 2'h2, 2'h2};

  slp_pin_config i_slp_pin_config (.clk_i, .reset_i, .indicator_pin_in_i(pin_level), .indicator_pin_out_o,
    .indicator_pin_oe_o, .test_strap_i, .address_strap_bit_i, .link_up_i, .link_speed_i, .activity_i,
    .interrupt_i, .jtag_tdo_i, .jtag_tdo_en_i, .jtag_tdi_o, .jtag_tms_o, .jtag_tck_o, .strap_done_o,
    .test_mode_o, .phy_addr_o, .mac_mode_o, .compact_rate_led_o, .mgmt_wr_i, .mgmt_rd_i, .mgmt_addr_i,
    .mgmt_wdata_i, .mgmt_rdata_o, .mgmt_rvalid_o);
  slp_board_model i_slp_board_model (.strap_i(board_strap), .pin_out_i(indicator_pin_out_o),
    .pin_oe_i(indicator_pin_oe_o), .pin_level_o(pin_level));

  // clock and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    mgmt_wr_i <= 1'b1;
    mgmt_addr_i <= a;
    mgmt_wdata_i <= d;
    @(posedge clk_i);
    mgmt_wr_i <= 1'b0;
  endtask

  // read one register and compare the one-cycle answer
  task automatic chk_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    mgmt_rd_i <= 1'b1;
    mgmt_addr_i <= a;
    @(posedge clk_i);
    mgmt_rd_i <= 1'b0;
    #1;
    chk_val({15'h0, mgmt_rvalid_o}, 16'h0001);
    chk_val(mgmt_rdata_o, exp);
  endtask

  task automatic chk_shadow(input logic [4:0] sh, input logic [15:0] exp);
    reg_write(5'h1c, {1'b0, sh, 10'h000});
    chk_reg(5'h1c, exp);
  endtask

  task automatic chk_pins(input logic [3:0] eoe, input logic [3:0] eout);
    repeat (3) @(posedge clk_i);
    #1;
    chk_val({8'h0, indicator_pin_oe_o, indicator_pin_out_o}, {8'h0, eoe, eout});
  endtask

  task automatic chk_cfg(input logic [4:0] ad, input slp_mac_mode_type m, input logic [1:0] ct);
    chk_val({7'h0, phy_addr_o, mac_mode_o, compact_rate_led_o, test_mode_o}, {7'h0, ad, m, ct});
  endtask

  // reset with given board straps, wait for capture
  task automatic boot(input logic [3:0] s, input logic [1:0] t, input logic a);
    @(posedge clk_i);
    board_strap <= s;
    test_strap_i <= t;
    address_strap_bit_i <= a;
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk_val({12'h0, indicator_pin_oe_o}, 16'h0000);
    @(posedge clk_i);
    reset_i <= 1'b0;
    for (int n = 0; n < 20 && strap_done_o !== 1'b1; n++) @(posedge clk_i);
    chk_val({15'h0, strap_done_o}, 16'h0001);
    @(posedge clk_i);
  endtask

  initial begin
    boot(4'h3, 2'h0, 1'b1);
    chk_cfg(5'h01, SLP_MAC_2V5, 2'h0);
    chk_shadow(5'h0d, 16'h3410);
    chk_shadow(5'h0e, 16'h3863);
    chk_reg(5'h05, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      link_up_i <= (k != 3);
      link_speed_i <= spd[k];
      chk_pins(4'h7, {2'h0, k[1:0] ^ 2'h3});
    end
    @(posedge clk_i);
    interrupt_i <= 1'b1;
    activity_i <= 1'b1;
    chk_pins(4'hf, 4'h4);
    reg_write(5'h10, 16'h1000);
    chk_pins(4'h7, 4'h4);
    reg_write(5'h10, 16'h0010);
    chk_pins(4'hf, 4'h4);
    reg_write(5'h10, 16'h0008);
    chk_pins(4'hf, 4'h3);
    reg_write(5'h10, 16'h0018);
    chk_pins(4'hf, 4'h4);
    reg_write(5'h10, 16'h0000);
    reg_write(5'h1c, {1'b1, 5'h0e, 10'h0ef});
    reg_write(5'h1c, {1'b1, 5'h0d, 10'h0ef});
    chk_pins(4'hf, 4'h6);
    chk_shadow(5'h0e, 16'h38ef);
    @(posedge clk_i);
    board_strap <= 4'hc;
    test_strap_i <= 2'h3;
    address_strap_bit_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk_cfg(5'h01, SLP_MAC_2V5, 2'h0);
    $display("test normal done");
    interrupt_i <= 1'b0;
    activity_i <= 1'b0;
    boot(4'hd, 2'h3, 1'b0);
    chk_cfg(5'h18, SLP_MAC_LOW_SWING, 2'h2);
    chk_shadow(5'h1e, 16'h7b5e);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      link_up_i <= (k != 3);
      link_speed_i <= spd[k];
      chk_pins(4'h7, {2'h1, compact_exp[k]});
    end
    $display("test compact done");
    boot(4'h6, 2'h0, 1'b0);
    chk_cfg(5'h00, SLP_MAC_RESERVED, 2'h0);
    $display("test reserved mode done");
    boot(4'h0, 2'h1, 1'b0);
    chk_cfg(5'h00, SLP_MAC_3V3, 2'h1);
    @(posedge clk_i);
    jtag_tdo_i <= 1'b1;
    jtag_tdo_en_i <= 1'b1;
    board_strap <= 4'h2;
    address_strap_bit_i <= 1'b1;
    chk_pins(4'h4, 4'h4);
    chk_val({13'h0, jtag_tdi_o, jtag_tms_o, jtag_tck_o}, 16'h0005);
    $display("test jtag done");
    print_verdict();
  end
endmodule
`default_nettype wire
